/* File: fmid_params.svh */
// Constants for the flash map and identification register bank.
// Assumes inclusion by the bank module and its testbench only.
`ifndef FMID_PARAMS_SVH
`define FMID_PARAMS_SVH
// Internal memory bus word addresses (flash control registers)
`define FMID_CTRL0_LO_ADDR 24'h080000
`define FMID_CTRL0_HI_ADDR 24'h080002
`define FMID_CTRL1_LO_ADDR 24'h080004
`define FMID_CTRL1_HI_ADDR 24'h080006
`define FMID_DATA0_LO_ADDR 24'h080008
`define FMID_DATA0_HI_ADDR 24'h08000a
`define FMID_DATA1_LO_ADDR 24'h08000c
`define FMID_DATA1_HI_ADDR 24'h08000e
`define FMID_ADR_LO_ADDR 24'h080010
`define FMID_ADR_HI_ADDR 24'h080012
`define FMID_ERR_ADDR 24'h080014
`define FMID_NVAP0_ADDR 24'h08dfb8
`define FMID_NVAP1L_ADDR 24'h08dfbc
`define FMID_NVAP1H_ADDR 24'h08dfbe
`define FMID_NVWP_ADDR 24'h0edfb0
// Extended peripheral bus address
`define FMID_VTAU0_ADDR 16'heb50
// Extended special-function space addresses
`define FMID_IDPV_ADDR 16'hf078
`define FMID_MEMID_ADDR 16'hf07a
`define FMID_CHIPID_ADDR 16'hf07c
`define FMID_IDMAKER_ADDR 16'hf07e
// Reset values
`define FMID_CTRL_RST 16'h0000
`define FMID_DATA_RST 16'hffff
`define FMID_NVAP0_RST 16'hacff
`define FMID_NVPROT_RST 16'hffff
`define FMID_VTAU_RST 16'hffff
// Identification fields
`define FMID_MEMTYPE_HPFLASH 4'h3
`define FMID_MEMORY_SIZE_FIELD_VAL 12'h040
`define FMID_PROG_SUPPLY_FIELD_VAL 8'h40
`define FMID_EXT_PROG_SUPPLY_FIELD_VAL 8'h00
`define FMID_BUSY_BITS 2'h3
// Flash initialisation time after reset, in ns, and its cycle count at 4 ns
`define FMID_INIT_NS 1000
`define FMID_CLK_NS 4
`define FMID_INIT_CYC ((`FMID_INIT_NS + `FMID_CLK_NS - 1) / `FMID_CLK_NS)
`endif

/* File: fmid_pkg.sv */
// Types shared by the flash map and identification bank.
// Assumes fmid_params.svh for all numeric constants.
package fmid_pkg;
   // One word access on any of the three register spaces
   typedef struct packed {
      logic sel;
      logic wr;
      logic [23:0] addr;
      logic [15:0] wdata;
   } fmid_req_t;
   // Read answer
   typedef struct packed {
      logic valid;
      logic hit;
      logic [15:0] rdata;
   } fmid_rsp_t;
   typedef enum logic [1:0] {
      FMID_MEM_NONE,
      FMID_MEM_ROM,
      FMID_MEM_STD,
      FMID_MEM_HP
   } fmid_memtype_t;
   typedef enum {FMID_INIT_RUN, FMID_INIT_DONE} fmid_init_t;
endpackage : fmid_pkg

/* File: fmid_bank.sv */
// Flash control register map and the four read-only identification words.
// Assumes each CPU bus presents a one-cycle word request synchronous to sys_clk;
// answers appear one cycle later from flip-flops.
`timescale 1ns/1ps
`include "fmid_params.svh"
module fmid_bank
   import fmid_pkg::*;
#(
   parameter int INIT_CYCLES = `FMID_INIT_CYC,
   parameter logic [11:0] CHIP_ID = 12'h5a5, // arbitrary value
   parameter logic [3:0] REV_ID = 4'h1, // arbitrary value
   parameter logic [15:0] MAKER_ID = 16'h0a5b // arbitrary value
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Boot select pin level, sampled when reset releases
   input wire logic bootSelectPin,
   // Internal memory bus
   input wire fmid_req_t ibusReq,
   output fmid_rsp_t ibusRsp,
   // Extended peripheral bus
   input wire fmid_req_t xbusReq,
   output fmid_rsp_t xbusRsp,
   // Extended special-function space
   input wire fmid_req_t esfrReq,
   output fmid_rsp_t esfrRsp,
   // Initialisation status
   output logic initDone
);
   // =====================================================================
   // Flash control storage
   localparam int NREG = 15;
   localparam logic [23:0] ADDRS [NREG] = '{`FMID_CTRL0_LO_ADDR, `FMID_CTRL0_HI_ADDR,
      `FMID_CTRL1_LO_ADDR, `FMID_CTRL1_HI_ADDR, `FMID_DATA0_LO_ADDR, `FMID_DATA0_HI_ADDR,
      `FMID_DATA1_LO_ADDR, `FMID_DATA1_HI_ADDR, `FMID_ADR_LO_ADDR, `FMID_ADR_HI_ADDR,
      `FMID_ERR_ADDR, `FMID_NVAP0_ADDR, `FMID_NVAP1L_ADDR, `FMID_NVAP1H_ADDR,
      `FMID_NVWP_ADDR};
   localparam logic [15:0] RSTV [NREG] = '{`FMID_CTRL_RST, `FMID_CTRL_RST,
      `FMID_CTRL_RST, `FMID_CTRL_RST, `FMID_DATA_RST, `FMID_DATA_RST,
      `FMID_DATA_RST, `FMID_DATA_RST, `FMID_CTRL_RST, `FMID_CTRL_RST,
      `FMID_CTRL_RST, `FMID_NVAP0_RST, `FMID_NVPROT_RST, `FMID_NVPROT_RST,
      `FMID_NVPROT_RST};

   logic [15:0] flashReg_r [NREG];
   logic [NREG-1:0] ibusHit;
   logic [15:0] vtau_r;

   // One word register per entry; decode is a full word address, no bit select
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_freg
         assign ibusHit[gi] = ibusReq.sel && (ibusReq.addr == ADDRS[gi]);
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               flashReg_r[gi] <= RSTV[gi];
            end else if (ibusHit[gi] && ibusReq.wr) begin
               flashReg_r[gi] <= ibusReq.wdata;
            end
         end
      end
   endgenerate

   // Internal bus read mux
   logic [15:0] ibusRd;
   always_comb begin
      ibusRd = 16'h0000;
      for (int i = 0; i < NREG; i++) begin
         if (ibusHit[i]) begin
            ibusRd = flashReg_r[i];
         end
      end
   end

   // Internal bus answer; unmapped reads return zero with hit low
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ibusRsp <= '0;
      end else begin
         ibusRsp.valid <= ibusReq.sel;
         ibusRsp.hit <= |ibusHit;
         ibusRsp.rdata <= ibusRd;
      end
   end

   // =====================================================================
   // Volatile unprotection register, peripheral bus only
   logic xbusHit;
   assign xbusHit = xbusReq.sel && (xbusReq.addr == {8'h00, `FMID_VTAU0_ADDR});

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         vtau_r <= `FMID_VTAU_RST;
      end else if (xbusHit && xbusReq.wr) begin
         vtau_r <= xbusReq.wdata;
      end
   end

   // Peripheral bus answer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         xbusRsp <= '0;
      end else begin
         xbusRsp.valid <= xbusReq.sel;
         xbusRsp.hit <= xbusHit;
         xbusRsp.rdata <= xbusHit ? vtau_r : 16'h0000;
      end
   end

   // =====================================================================
   // Flash initialisation sequencer
   fmid_init_t initState_r;
   logic [$clog2(INIT_CYCLES+1)-1:0] initCnt_r;
   logic bootSampled_r;

   // Strap caught on the first clock after release; async reset takes constants only
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bootSampled_r <= 1'b0;
      end else begin
         bootSampled_r <= 1'b1;
      end
   end

   // Internal boot skips the wait: flash is already initialised at release
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         initState_r <= FMID_INIT_RUN;
         initCnt_r <= '0;
      end else begin
         case (initState_r)
            FMID_INIT_RUN: begin
               if (!bootSampled_r && bootSelectPin) begin
                  initState_r <= FMID_INIT_DONE;
               end else if (initCnt_r == ($bits(initCnt_r))'(INIT_CYCLES - 1)) begin
                  initState_r <= FMID_INIT_DONE;
               end else begin
                  initCnt_r <= initCnt_r + 1'b1;
               end
            end
            FMID_INIT_DONE: initState_r <= FMID_INIT_DONE;
            default: initState_r <= FMID_INIT_RUN;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         initDone <= 1'b0;
      end else begin
         initDone <= (initState_r == FMID_INIT_DONE);
      end
   end

   // =====================================================================
   // Identification words, constant except the busy bits
   logic [15:0] memory_type_size_ident;
   logic [15:0] programming_voltage_ident;
   logic [15:0] chip_revision_ident;
   logic esfrHit;
   logic [15:0] esfrRd;
   fmid_memtype_t memType;
   assign memType = FMID_MEM_HP;
   // Top two bits read as busy until initialisation ends, the software poll point
   assign memory_type_size_ident = (initState_r == FMID_INIT_DONE) ?
      {2'b00, 2'(memType), `FMID_MEMORY_SIZE_FIELD_VAL} :
      {`FMID_BUSY_BITS, 2'(memType), `FMID_MEMORY_SIZE_FIELD_VAL};
   assign programming_voltage_ident = {`FMID_EXT_PROG_SUPPLY_FIELD_VAL, `FMID_PROG_SUPPLY_FIELD_VAL};
   assign chip_revision_ident = {CHIP_ID, REV_ID};

   // Read-only decode; write strobes are not looked at
   always_comb begin
      esfrHit = esfrReq.sel;
      case (esfrReq.addr[15:0])
         `FMID_IDPV_ADDR: esfrRd = programming_voltage_ident;
         `FMID_MEMID_ADDR: esfrRd = memory_type_size_ident;
         `FMID_CHIPID_ADDR: esfrRd = chip_revision_ident;
         `FMID_IDMAKER_ADDR: esfrRd = MAKER_ID;
         default: begin
            esfrRd = 16'h0000;
            esfrHit = 1'b0;
         end
      endcase
      if (esfrReq.addr[23:16] != 8'h00) begin
         esfrHit = 1'b0;
         esfrRd = 16'h0000;
      end
   end

   // Extended special-function answer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         esfrRsp <= '0;
      end else begin
         esfrRsp.valid <= esfrReq.sel;
         esfrRsp.hit <= esfrHit;
         esfrRsp.rdata <= esfrRd;
      end
   end

   // =====================================================================
   // Assertions
   property p_busyBits;
      @(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_MEMID_ADDR} && !initDone
      && initState_r != FMID_INIT_DONE |=> esfrRsp.rdata[15:14] == 2'b11;
   endproperty
   busy_bits_set_a: assert property (p_busyBits)
      else $error("memory ident busy bits not set");
   mem_ready_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_MEMID_ADDR} && initDone
      |=> esfrRsp.rdata == 16'h3040)
      else $error("memory ident wrong after init");
   prog_word_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_IDPV_ADDR}
      |=> esfrRsp.rdata == 16'h0040 && esfrRsp.hit)
      else $error("programming voltage word wrong");
   chip_word_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_CHIPID_ADDR}
      |=> esfrRsp.rdata[3:0] == REV_ID)
      else $error("revision nibble wrong");
   init_stays_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      initDone |=> initDone)
      else $error("initialisation status fell back");
   init_bound_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(bootSampled_r) |-> ##[1:300] initDone)
      else $error("initialisation did not finish");
   boot_fast_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(bootSampled_r) && $past(bootSelectPin) |-> ##1 initDone)
      else $error("internal boot not immediately ready");
   data_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(bootSampled_r) |-> flashReg_r[4] == 16'hffff || $past(ibusHit[4]))
      else $error("data register reset value wrong");
   nvap_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ibusHit[11] && !ibusReq.wr |=> ibusRsp.rdata == $past(flashReg_r[11]))
      else $error("protection register read wrong");
   vtau_extended_peripheral_bus_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ibusReq.sel && ibusReq.addr == {8'h00, `FMID_VTAU0_ADDR} |=> !ibusRsp.hit)
      else $error("unprotect register seen on internal bus");
   cov_ext_boot_c: cover property (@(posedge sys_clk) disable iff (!resetn)
      $rose(initDone) && !bootSelectPin);
   cov_flash_wr_c: cover property (@(posedge sys_clk) disable iff (!resetn)
      ibusReq.sel && ibusReq.wr && |ibusHit);
   cov_id_wr_c: cover property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.wr && esfrHit);
   cov_int_boot_c: cover property (@(posedge sys_clk) disable iff (!resetn)
      $rose(initDone) && bootSelectPin);
   cov_busy_read_c: cover property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_MEMID_ADDR} && !initDone);

   // =====================================================================
   // Bus answer timing and decode on the internal and peripheral buses

   // Every request gets exactly one answer on the next cycle
   internal_memory_bus_valid_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ibusReq.sel |=> ibusRsp.valid)
      else $error("internal bus answer missing");
   // No answer appears without a request
   internal_memory_bus_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !ibusReq.sel |=> !ibusRsp.valid)
      else $error("internal bus answer without request");
   // Unmapped internal bus words read zero and miss
   internal_memory_bus_miss_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ibusReq.sel && !(|ibusHit) |=> !ibusRsp.hit && ibusRsp.rdata == 16'h0000)
      else $error("unmapped internal bus word answered");
   // Peripheral bus read returns the unprotect register as it stood
   extended_peripheral_bus_vtau_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      xbusHit && !xbusReq.wr |=> xbusRsp.rdata == $past(vtau_r) && xbusRsp.hit)
      else $error("unprotect register read wrong");
   // Flash control words are not reachable from the peripheral bus
   extended_peripheral_bus_flash_miss_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      xbusReq.sel && xbusReq.addr == `FMID_CTRL0_LO_ADDR |=> !xbusRsp.hit)
      else $error("flash register seen on peripheral bus");
   // Peripheral bus answers every request on the next cycle
   extended_peripheral_bus_valid_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      xbusReq.sel |=> xbusRsp.valid)
      else $error("peripheral bus answer missing");

   // =====================================================================
   // Whole-word stores; a partial store would leave stale bits behind

   // Control word takes the full written value
   word_store_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ibusHit[0] && ibusReq.wr |=> flashReg_r[0] == $past(ibusReq.wdata))
      else $error("control word store incomplete");
   // Unprotect register takes the full written value
   vtau_store_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      xbusHit && xbusReq.wr |=> vtau_r == $past(xbusReq.wdata))
      else $error("unprotect word store incomplete");

   // =====================================================================
   // Identification words

   // Flash words never show up in the special-function space
   extended_special_function_space_flash_miss_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == `FMID_CTRL0_LO_ADDR
      |=> !esfrRsp.hit && esfrRsp.rdata == 16'h0000)
      else $error("flash register seen in special-function space");
   // Maker word reads its fixed value
   maker_word_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_IDMAKER_ADDR}
      |=> esfrRsp.rdata == MAKER_ID && esfrRsp.hit)
      else $error("maker word wrong");
   // Device field sits above the revision nibble
   chip_field_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_CHIPID_ADDR}
      |=> esfrRsp.rdata[15:4] == CHIP_ID)
      else $error("device field wrong");
   // Memory type reads high-performance flash before and after init
   mem_type_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_MEMID_ADDR}
      |=> esfrRsp.rdata[13:12] == 2'h3)
      else $error("memory type field wrong");
   // No external programming supply is ever reported
   vpp_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_IDPV_ADDR}
      |=> esfrRsp.rdata[15:8] == 8'h00)
      else $error("external programming supply not zero");
   // Busy bits clear once init is reported done
   busy_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.addr == {8'h00, `FMID_MEMID_ADDR} && initDone
      |=> esfrRsp.rdata[15:14] == 2'b00)
      else $error("busy bits still set after init");
   // A write to an identification word still answers as a hit
   id_write_hit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      esfrReq.sel && esfrReq.wr && esfrHit |=> esfrRsp.hit && esfrRsp.valid)
      else $error("identification write not answered");
endmodule : fmid_bank

/* File: fmid_bank_tb.sv */
// Self-checking bench for the flash map and identification register bank.
// Assumes fmid_pkg, fmid_params.svh and fmid_bank are compiled before it.
`timescale 1ns/1ps
`include "fmid_params.svh"
module fmid_bank_tb;
   import fmid_pkg::*;
   // ==========================================================
   // Bench constants and table row type
   localparam logic [11:0] CHIP = 12'h5a5; // arbitrary value
   localparam logic [3:0] REV = 4'h3; // arbitrary value
   localparam logic [15:0] MAKER = 16'h6c2e; // arbitrary value
   localparam logic [1:0] IB = 2'h0;
   localparam logic [1:0] XB = 2'h1;
   localparam logic [1:0] ES = 2'h2;
   localparam logic [23:0] A_PV = {8'h00, `FMID_IDPV_ADDR};
   localparam logic [23:0] A_MEM = {8'h00, `FMID_MEMID_ADDR};
   localparam logic [23:0] A_CHIP = {8'h00, `FMID_CHIPID_ADDR};
   localparam logic [23:0] A_MAKER = {8'h00, `FMID_IDMAKER_ADDR};
   localparam logic [23:0] A_VTAU = {8'h00, `FMID_VTAU0_ADDR};
   typedef struct packed {
      logic [1:0] bus;
      logic wr;
      logic [23:0] addr;
      logic [15:0] wd;
      logic hit;
      logic [15:0] rd;
   } fmid_row_t;
   logic sys_clk;
   logic resetn;
   logic bootSelectPin;
   fmid_req_t ibusReq, xbusReq, esfrReq;
   fmid_rsp_t ibusRsp, xbusRsp, esfrRsp;
   logic initDone;
   int n_errors;
   int checks;
   fmid_row_t rows[$];
   // ==========================================================
   // Device under test, short init count keeps the run brief
   fmid_bank #(.INIT_CYCLES(8), .CHIP_ID(CHIP), .REV_ID(REV), .MAKER_ID(MAKER)) fmid_bank_inst (
      .sys_clk(sys_clk), .resetn(resetn), .bootSelectPin(bootSelectPin),
      .ibusReq(ibusReq), .ibusRsp(ibusRsp), .xbusReq(xbusReq), .xbusRsp(xbusRsp),
      .esfrReq(esfrReq), .esfrRsp(esfrRsp), .initDone(initDone));
   // Clock at 4 ns
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // ==========================================================
   // Helpers
   function automatic fmid_row_t mk(logic [1:0] b, logic w, logic [23:0] a, logic [15:0] d,
                                    logic h, logic [15:0] r);
      return '{bus:b, wr:w, addr:a, wd:d, hit:h, rd:r};
   endfunction : mk
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One word access: request held one cycle, answer sampled 1 ns after it drops
   task automatic run(input logic [1:0] b, input logic w, input logic [23:0] a,
                      input logic [15:0] d, input logic h, input logic [15:0] rd);
      fmid_req_t q;
      fmid_rsp_t r;
      q = '{sel:1'b1, wr:w, addr:a, wdata:d};
      @(posedge sys_clk);
      case (b)
         IB: ibusReq <= q;
         XB: xbusReq <= q;
         default: esfrReq <= q;
      endcase
      @(posedge sys_clk);
      ibusReq <= '0;
      xbusReq <= '0;
      esfrReq <= '0;
      #1;
      r = (b == IB) ? ibusRsp : ((b == XB) ? xbusRsp : esfrRsp);
      chk({14'h0000, r.valid, r.hit}, {14'h0000, 1'b1, h});
      if (!w) chk(r.rdata, rd);
   endtask : run
   task automatic print_verdict();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // Watchdog, whole run needs well under a microsecond
   initial begin
      #20000;
      n_errors++;
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      bootSelectPin = 1'b0;
      ibusReq = '0;
      xbusReq = '0;
      esfrReq = '0;
      n_errors = 0;
      checks = 0;
      rows = {
         mk(IB, 0, `FMID_CTRL0_LO_ADDR, 0, 1, 16'h0000), mk(IB, 0, `FMID_CTRL0_HI_ADDR, 0, 1, 16'h0000),
         mk(IB, 0, `FMID_CTRL1_LO_ADDR, 0, 1, 16'h0000), mk(IB, 0, `FMID_CTRL1_HI_ADDR, 0, 1, 16'h0000),
         mk(IB, 0, `FMID_DATA0_LO_ADDR, 0, 1, 16'hffff), mk(IB, 0, `FMID_DATA0_HI_ADDR, 0, 1, 16'hffff),
         mk(IB, 0, `FMID_DATA1_LO_ADDR, 0, 1, 16'hffff), mk(IB, 0, `FMID_DATA1_HI_ADDR, 0, 1, 16'hffff),
         mk(IB, 0, `FMID_ADR_LO_ADDR, 0, 1, 16'h0000), mk(IB, 0, `FMID_ADR_HI_ADDR, 0, 1, 16'h0000),
         mk(IB, 0, `FMID_ERR_ADDR, 0, 1, 16'h0000), mk(IB, 0, `FMID_NVAP0_ADDR, 0, 1, 16'hacff),
         mk(IB, 0, `FMID_NVAP1L_ADDR, 0, 1, 16'hffff), mk(IB, 0, `FMID_NVAP1H_ADDR, 0, 1, 16'hffff),
         mk(IB, 0, `FMID_NVWP_ADDR, 0, 1, 16'hffff), mk(XB, 0, A_VTAU, 0, 1, 16'hffff),
         // Wrong bus or unmapped word gives a miss
         mk(IB, 0, A_VTAU, 0, 0, 16'h0000), mk(ES, 0, `FMID_CTRL0_LO_ADDR, 0, 0, 16'h0000),
         mk(XB, 0, `FMID_CTRL0_LO_ADDR, 0, 0, 16'h0000),
         mk(IB, 0, 24'h080016, 0, 0, 16'h0000), mk(ES, 0, 24'h00f076, 0, 0, 16'h0000),
         // Identification words
         mk(ES, 0, A_PV, 0, 1, 16'h0040), mk(ES, 0, A_MEM, 0, 1, 16'h3040),
         mk(ES, 0, A_CHIP, 0, 1, {CHIP, REV}), mk(ES, 0, A_MAKER, 0, 1, MAKER),
         // Whole-word writes, each read back by the next access
         mk(IB, 1, `FMID_CTRL0_LO_ADDR, 16'ha5c3, 1, 0), mk(IB, 0, `FMID_CTRL0_LO_ADDR, 0, 1, 16'ha5c3),
         mk(IB, 1, `FMID_DATA1_HI_ADDR, 16'h0f0f, 1, 0), mk(IB, 0, `FMID_DATA1_HI_ADDR, 0, 1, 16'h0f0f),
         mk(IB, 1, `FMID_NVWP_ADDR, 16'h1357, 1, 0), mk(IB, 0, `FMID_NVWP_ADDR, 0, 1, 16'h1357),
         mk(XB, 1, A_VTAU, 16'h2468, 1, 0), mk(XB, 0, A_VTAU, 0, 1, 16'h2468),
         // Writes to read-only identification words leave them alone
         mk(ES, 1, A_CHIP, 16'hffff, 1, 0), mk(ES, 0, A_CHIP, 0, 1, {CHIP, REV}),
         mk(ES, 1, A_PV, 16'hffff, 1, 0), mk(ES, 0, A_PV, 0, 1, 16'h0040),
         mk(ES, 1, A_MAKER, 16'h0000, 1, 0), mk(ES, 0, A_MAKER, 0, 1, MAKER)
      };
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      // External boot: busy bits stand until init ends, write cannot clear them
      run(ES, 0, A_MEM, 0, 1, 16'hf040);
      run(ES, 1, A_MEM, 16'h0000, 1, 0);
      run(ES, 0, A_MEM, 0, 1, 16'hf040);
      chk({15'h0000, initDone}, 16'h0000);
      run(ES, 0, A_PV, 0, 1, 16'h0040);
      for (int i = 0; i < 40 && initDone !== 1'b1; i++) @(posedge sys_clk);
      chk({15'h0000, initDone}, 16'h0001);
      run(ES, 0, A_MEM, 0, 1, 16'h3040);
      // Table of ordinary accesses
      foreach (rows[i]) run(rows[i].bus, rows[i].wr, rows[i].addr, rows[i].wd, rows[i].hit, rows[i].rd);
      // Internal boot in mid-run: contents ready at once, registers back to reset
      @(posedge sys_clk);
      resetn <= 1'b0;
      bootSelectPin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      run(ES, 0, A_MEM, 0, 1, 16'h3040);
      chk({15'h0000, initDone}, 16'h0001);
      run(IB, 0, `FMID_CTRL0_LO_ADDR, 0, 1, 16'h0000);
      run(IB, 0, `FMID_DATA1_HI_ADDR, 0, 1, 16'hffff);
      run(IB, 0, `FMID_NVWP_ADDR, 0, 1, 16'hffff);
      run(XB, 0, A_VTAU, 0, 1, 16'hffff);
      print_verdict();
   end
endmodule : fmid_bank_tb
